/* inc/plc_pkg.sv */
// loop calibration config package: register map, fields, resets, wait counts
// assumes a 50 MHz pclk; all consumers import plc_pkg::*
//
// Operation
// - loop1 filter select resets 3; 3=2nd,7=3rd
// - closed wait codes: 30us,300us,30ms,300ms; reset 0
// - oscillator wait codes: 20us,400us,8ms,200ms; reset 1
// - bandwidth bit 0 set narrows loop; resets 0
// - loop2 stretch bit 7: 200ps/600ps; reset 0
// - loop1 stretch bit 7 likewise; reset 0
package plc_pkg;
   ////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_L1_STRETCH = 8'h75;
   localparam logic [7:0] IDX_L1_FILTER  = 8'h76;
   localparam logic [7:0] IDX_L1_WAITS   = 8'h77;
   localparam logic [7:0] IDX_L1_BW      = 8'h78;
   localparam logic [7:0] IDX_L2_STRETCH = 8'h83;
   localparam logic [7:0] IDX_CAL_CTRL   = 8'h90;
   localparam logic [7:0] IDX_CAL_STAT   = 8'h91;
   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int STRETCH_BIT = 7;
   localparam int FILTER_LSB  = 0;
   localparam int CLSD_LSB    = 2;
   localparam int OSC_LSB     = 0;
   localparam int BW_BIT      = 0;
   localparam int START_BIT   = 0;
   localparam int BUSY_BIT    = 0;
   localparam int DONE_BIT    = 1;
   // reset values
   localparam logic [2:0] FILTER_RST  = 3'h3;
   localparam logic [1:0] CLSD_RST    = 2'h0;
   localparam logic [1:0] OSC_RST     = 2'h1;
   localparam logic       BW_RST      = 1'b0;
   localparam logic       STRETCH_RST = 1'b0;
   // filter select codes
   localparam logic [2:0] FILTER_2ND = 3'h3;
   localparam logic [2:0] FILTER_3RD = 3'h7;
   ////////////////////////////////////////////////////////////////////////
   // wait times in ns and derived cycle counts (least time, rounded up)
   localparam int CLK_PERIOD_NS = 20;
   localparam int CNT_W         = 24;
   localparam int CLSD0_NS = 30000;
   localparam int CLSD1_NS = 300000;
   localparam int CLSD2_NS = 30000000;
   localparam int CLSD3_NS = 300000000;
   localparam int OSC0_NS  = 20000;
   localparam int OSC1_NS  = 400000;
   localparam int OSC2_NS  = 8000000;
   localparam int OSC3_NS  = 200000000;
   localparam int CLSD0_CYC = (CLSD0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLSD1_CYC = (CLSD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLSD2_CYC = (CLSD2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CLSD3_CYC = (CLSD3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC0_CYC  = (OSC0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC1_CYC  = (OSC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC2_CYC  = (OSC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OSC3_CYC  = (OSC3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {CAL_IDLE, CAL_OSC, CAL_CLSD} plc_cal_e;
endpackage

/* inc/plc_reg_if.sv */
// register access carrier between the apb slave and the register bank
// assumes both ends sit on pclk
`timescale 1ns/10ps
`default_nettype none
interface plc_reg_if;
   logic       wr_en;
   logic [7:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       hit;
   modport slave (output wr_en, idx, wdata, input rdata, hit);
   modport regs  (input wr_en, idx, wdata, output rdata, hit);
endinterface
`default_nettype wire

/* rtl/plc_apb_slave.sv */
// apb slave: no wait states, registered answer, error on unmapped address
// assumes the register bank answers rdata/hit combinationally from idx
`timescale 1ns/10ps
`default_nettype none
module plc_apb_slave
   import plc_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // register side
   plc_reg_if.slave         bus
);
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } plc_apb_s;
   plc_apb_s q;
   plc_apb_s next_q;
   logic     aligned;

   ////////////////////////////////////////////////////////////////////////
   // decode; upper and lowest address bits must be zero to hit
   assign aligned   = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
   assign bus.idx   = paddr[9:2];
   assign bus.wdata = pwdata[7:0];
   // write lands only on the edge that completes the access
   assign bus.wr_en = psel && penable && q.pready && pwrite && aligned && bus.hit;

   // answer is prepared in setup so the access phase shows it for one cycle
   always_comb begin
      next_q        = q;
      next_q.pready = 1'b0;
      if (psel && !penable) begin
         next_q.pready  = 1'b1;
         next_q.pslverr = !(aligned && bus.hit);
         next_q.prdata  = (pwrite || !(aligned && bus.hit)) ? 32'h0 : {24'h0, bus.rdata};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign prdata  = q.prdata;
   assign pready  = q.pready;
   assign pslverr = q.pslverr;

   chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready held over two cycles");
endmodule
`default_nettype wire

/* rtl/plc_top.sv */
// loop calibration configuration bank with apb access and wait sequencer
// assumes pclk at 50 MHz stands in for the always-on clock; nvm loader
// runs on pclk and presents one register index and byte per pulse
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module plc_top
   import plc_pkg::*;
#(
   // long wait counts, shortened in simulation
   parameter logic [CNT_W-1:0] CLSD1_CYCLES = CNT_W'(CLSD1_CYC),
   parameter logic [CNT_W-1:0] CLSD2_CYCLES = CNT_W'(CLSD2_CYC),
   parameter logic [CNT_W-1:0] CLSD3_CYCLES = CNT_W'(CLSD3_CYC),
   parameter logic [CNT_W-1:0] OSC1_CYCLES  = CNT_W'(OSC1_CYC),
   parameter logic [CNT_W-1:0] OSC2_CYCLES  = CNT_W'(OSC2_CYC),
   parameter logic [CNT_W-1:0] OSC3_CYCLES  = CNT_W'(OSC3_CYC)
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // start-up load from non-volatile storage
   input  wire logic        nvm_load,
   input  wire logic [7:0]  nvm_index,
   input  wire logic [7:0]  nvm_data,
   // loop controls
   output logic [2:0]       loop1_filter_order_sel,
   output logic [1:0]       closed_loop_wait_sel,
   output logic [1:0]       oscillator_wait_sel,
   output logic             loop1_narrow_bandwidth,
   output logic             loop1_pulse_stretch_en,
   output logic             loop2_pulse_stretch_en,
   // calibration status
   output logic             cal_busy,
   output logic             cal_done
);
   typedef struct packed {
      logic [2:0] filt;
      logic [1:0] clsd;
      logic [1:0] osc;
      logic       bw;
      logic       st1;
      logic       st2;
      plc_cal_e   st;
      logic       busy;
      logic       done;
   } plc_top_s;
   plc_top_s q;
   plc_top_s next_q;

   plc_reg_if reg_if ();

   logic             tmr_load;
   logic [CNT_W-1:0] tmr_cnt;
   logic             tmr_done;
   logic             start_req;

   ////////////////////////////////////////////////////////////////////////
   // wait code to cycle count tables
   function automatic logic [CNT_W-1:0] clsd_cycles(input logic [1:0] code);
      logic [CNT_W-1:0] r;
      unique case (code)
         2'h0: r = CNT_W'(CLSD0_CYC);
         2'h1: r = CLSD1_CYCLES;
         2'h2: r = CLSD2_CYCLES;
         2'h3: r = CLSD3_CYCLES;
      endcase
      return r;
   endfunction

   function automatic logic [CNT_W-1:0] osc_cycles(input logic [1:0] code);
      logic [CNT_W-1:0] r;
      unique case (code)
         2'h0: r = CNT_W'(OSC0_CYC);
         2'h1: r = OSC1_CYCLES;
         2'h2: r = OSC2_CYCLES;
         2'h3: r = OSC3_CYCLES;
      endcase
      return r;
   endfunction

   // register image for an index; reserved bits read zero
   function automatic logic [8:0] read_value(input logic [7:0] idx, input plc_top_s s);
      logic [8:0] r;
      r = 9'h0;
      unique case (idx)
         IDX_L1_STRETCH: r[STRETCH_BIT] = s.st1;
         IDX_L1_FILTER:  r[FILTER_LSB +: 3] = s.filt;
         IDX_L1_WAITS: begin
            r[CLSD_LSB +: 2] = s.clsd;
            r[OSC_LSB +: 2]  = s.osc;
         end
         IDX_L1_BW:      r[BW_BIT] = s.bw;
         IDX_L2_STRETCH: r[STRETCH_BIT] = s.st2;
         IDX_CAL_CTRL:   r = 9'h0;
         IDX_CAL_STAT: begin
            r[BUSY_BIT] = s.busy;
            r[DONE_BIT] = s.done;
         end
         default:        r = 9'h0;
      endcase
      r[8] = (idx == IDX_L1_STRETCH) || (idx == IDX_L1_FILTER) ||
             (idx == IDX_L1_WAITS) || (idx == IDX_L1_BW) ||
             (idx == IDX_L2_STRETCH) || (idx == IDX_CAL_CTRL) ||
             (idx == IDX_CAL_STAT);
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // bus slave
   plc_apb_slave u_apb (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr),
      .bus     (reg_if.slave)
   );

   // read path and address hit
   logic [8:0] rd_word;
   assign rd_word      = read_value(reg_if.idx, q);
   assign reg_if.rdata = rd_word[7:0];
   assign reg_if.hit   = rd_word[8];

   ////////////////////////////////////////////////////////////////////////
   // shared wait timer; one count at a time is enough for a serial sequence
   plc_wait_timer #(
      .W (CNT_W)
   ) u_tmr (
      .pclk     (pclk),
      .presetn  (presetn),
      .load     (tmr_load),
      .load_cnt (tmr_cnt),
      .done     (tmr_done),
      .busy     ()
   );

   assign start_req = reg_if.wr_en && (reg_if.idx == IDX_CAL_CTRL) &&
                      reg_if.wdata[START_BIT];

   // timer loads: oscillator wait on start, closed-loop wait after it
   always_comb begin
      tmr_load = 1'b0;
      tmr_cnt  = '0;
      if (q.st == CAL_IDLE && start_req) begin
         tmr_load = 1'b1;
         tmr_cnt  = osc_cycles(q.osc);
      end else if (q.st == CAL_OSC && tmr_done) begin
         tmr_load = 1'b1;
         tmr_cnt  = clsd_cycles(q.clsd);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // field updates: nvm load first, a bus write in the same cycle wins;
   // only defined field bits are taken from either source
   always_comb begin
      next_q = q;
      if (nvm_load) begin
         unique case (nvm_index)
            IDX_L1_STRETCH: next_q.st1 = nvm_data[STRETCH_BIT];
            IDX_L1_FILTER:  next_q.filt = nvm_data[FILTER_LSB +: 3];
            IDX_L1_WAITS: begin
               next_q.clsd = nvm_data[CLSD_LSB +: 2];
               next_q.osc  = nvm_data[OSC_LSB +: 2];
            end
            IDX_L1_BW:      next_q.bw = nvm_data[BW_BIT];
            IDX_L2_STRETCH: next_q.st2 = nvm_data[STRETCH_BIT];
            default: ;
         endcase
      end
      if (reg_if.wr_en) begin
         unique case (reg_if.idx)
            IDX_L1_STRETCH: next_q.st1 = reg_if.wdata[STRETCH_BIT];
            IDX_L1_FILTER:  next_q.filt = reg_if.wdata[FILTER_LSB +: 3];
            IDX_L1_WAITS: begin
               next_q.clsd = reg_if.wdata[CLSD_LSB +: 2];
               next_q.osc  = reg_if.wdata[OSC_LSB +: 2];
            end
            IDX_L1_BW:      next_q.bw = reg_if.wdata[BW_BIT];
            IDX_L2_STRETCH: next_q.st2 = reg_if.wdata[STRETCH_BIT];
            default: ;
         endcase
      end
      // sequencer: oscillator wait, then closed-loop wait, then done
      unique case (q.st)
         CAL_IDLE: begin
            if (start_req) begin
               next_q.st   = CAL_OSC;
               next_q.busy = 1'b1;
               next_q.done = 1'b0;
            end
         end
         CAL_OSC: begin
            if (tmr_done) begin
               next_q.st = CAL_CLSD;
            end
         end
         CAL_CLSD: begin
            if (tmr_done) begin
               next_q.st   = CAL_IDLE;
               next_q.busy = 1'b0;
               next_q.done = 1'b1;
            end
         end
         default: begin
            next_q.st   = CAL_IDLE;
            next_q.busy = 1'b0;
         end
      endcase
   end

   // reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.filt <= FILTER_RST;
         q.clsd <= CLSD_RST;
         q.osc  <= OSC_RST;
         q.bw   <= BW_RST;
         q.st1  <= STRETCH_RST;
         q.st2  <= STRETCH_RST;
         q.st   <= CAL_IDLE;
         q.busy <= 1'b0;
         q.done <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign loop1_filter_order_sel = q.filt;
   assign closed_loop_wait_sel   = q.clsd;
   assign oscillator_wait_sel    = q.osc;
   assign loop1_narrow_bandwidth = q.bw;
   assign loop1_pulse_stretch_en = q.st1;
   assign loop2_pulse_stretch_en = q.st2;
   assign cal_busy               = q.busy;
   assign cal_done               = q.done;

   ////////////////////////////////////////////////////////////////////////
   // checks
   chk_filter_reset_val: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> loop1_filter_order_sel == FILTER_2ND)
      else $error("filter select not 3 after reset");

   chk_filter_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
      (reg_if.wr_en && reg_if.idx == IDX_L1_FILTER) |=>
      loop1_filter_order_sel == $past(reg_if.wdata[2:0]))
      else $error("filter select write lost");

   chk_clsd_wait_count: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st == CAL_OSC && tmr_done && q.clsd == 2'h0) |->
      tmr_load && tmr_cnt == CNT_W'(1500))
      else $error("closed wait code 0 not 1500 cycles");

   chk_osc_wait_count: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st == CAL_IDLE && start_req && q.osc == 2'h0) |->
      tmr_load && tmr_cnt == CNT_W'(1000))
      else $error("oscillator wait code 0 not 1000 cycles");

   chk_waits_reset_val: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> oscillator_wait_sel == 2'h1 &&
      closed_loop_wait_sel == 2'h0 && !loop1_narrow_bandwidth)
      else $error("wait or bandwidth reset value wrong");

   chk_stretch2_read: assert property (@(posedge pclk) disable iff (!presetn)
      (reg_if.idx == IDX_L2_STRETCH) |->
      reg_if.rdata == {loop2_pulse_stretch_en, 7'h0})
      else $error("loop2 stretch not at bit 7");

   chk_stretch1_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == {2'h0, IDX_L1_STRETCH, 2'h0}) |=>
      prdata == {24'h0, loop1_pulse_stretch_en, 7'h0})
      else $error("loop1 stretch read wrong");

   // a load of the bandwidth byte takes bit 0 only and leaves the filter and wait fields alone
   chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (nvm_load && nvm_index == IDX_L1_BW && !reg_if.wr_en) |=>
      loop1_narrow_bandwidth == $past(nvm_data[BW_BIT]) &&
      $stable({loop1_filter_order_sel, closed_loop_wait_sel, oscillator_wait_sel}))
      else $error("reserved bits loaded");

   chk_cal_sequence: assert property (@(posedge pclk) disable iff (!presetn)
      (q.st == CAL_CLSD && tmr_done) |=> !cal_busy && cal_done)
      else $error("calibration end not reported");
endmodule
`default_nettype wire

/* rtl/plc_wait_timer.sv */
// stabilization wait counter: load a cycle count, get a done pulse after it
// assumes load is only raised while idle
`timescale 1ns/10ps
`default_nettype none
module plc_wait_timer
   import plc_pkg::*;
#(
   parameter int W = CNT_W
) (
   // clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] load_cnt,
   output logic              done,
   output logic              busy
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         busy;
      logic         done;
   } plc_tmr_s;
   plc_tmr_s q;
   plc_tmr_s next_q;

   ////////////////////////////////////////////////////////////////////////
   // done rises exactly load_cnt edges after the load edge
   always_comb begin
      next_q      = q;
      next_q.done = 1'b0;
      if (load) begin
         next_q.cnt  = load_cnt;
         next_q.busy = 1'b1;
      end else if (q.busy) begin
         if (q.cnt <= W'(1)) begin
            next_q.busy = 1'b0;
            next_q.done = 1'b1;
         end else begin
            next_q.cnt = q.cnt - W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign done = q.done;
   assign busy = q.busy;

   chk_done_after_last: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(done) |-> $past(busy) && ($past(q.cnt) <= W'(1)))
      else $error("timer done without reaching last count");
endmodule
`default_nettype wire

/* verif/pll_loop_calibration_config_bench.sv */
// self-checking bench for plc_top: apb register access, nvm load, wait sequencer
// assumes plc_pkg compiled first; long waits shortened through top parameters
`timescale 1ns/10ps
`default_nettype none
module pll_loop_calibration_config_bench;
   import plc_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // stimulus and observed signals
   logic        pclk, presetn, psel, penable, pwrite, nvm_load, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0]  nvm_index, nvm_data;
   logic [2:0]  filt;
   logic [1:0]  clsd, osc;
   logic        bw, s1, s2, cal_busy, cal_done;
   int          fails, n_compared;
   // bench register mirror, same order as the index table
   localparam logic [7:0] IDX[5] = '{IDX_L1_STRETCH, IDX_L1_FILTER, IDX_L1_WAITS,
                                     IDX_L1_BW, IDX_L2_STRETCH};
   localparam logic [7:0] MSK[5] = '{8'h80, 8'h07, 8'h0f, 8'h01, 8'h80};
   // short wait lengths keep the run small; oscillator code 1 keeps its
   // full 400 us count so one table entry is checked at its real length
   localparam int OSC_N[4]  = '{1000, 20000, 25, 35};
   localparam int CLSD_N[4] = '{1500, 30, 40, 50};
   logic [7:0] mir[5];
   ////////////////////////////////////////////////////////////////////////
   plc_top #(
      .CLSD1_CYCLES(24'd30), .CLSD2_CYCLES(24'd40), .CLSD3_CYCLES(24'd50),
      .OSC2_CYCLES (24'd25), .OSC3_CYCLES (24'd35)
   ) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nvm_load(nvm_load),
      .nvm_index(nvm_index), .nvm_data(nvm_data),
      .loop1_filter_order_sel(filt), .closed_loop_wait_sel(clsd),
      .oscillator_wait_sel(osc), .loop1_narrow_bandwidth(bw),
      .loop1_pulse_stretch_en(s1), .loop2_pulse_stretch_en(s2),
      .cal_busy(cal_busy), .cal_done(cal_done)
   );
   ////////////////////////////////////////////////////////////////////////
   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) chk("pready", 32'h1, 32'h0);
   endtask
   task automatic wr(input int i, input logic [7:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, IDX[i], {24'h0, d}, rd, er);
      mir[i] = d & MSK[i];
      chk("write error", 32'h0, {31'h0, er});
   endtask
   // reads the five mirrored registers back and checks the field outputs against the mirror
   task automatic check_all(input string tname);
      logic [31:0] rd;
      logic        er;
      @(posedge pclk);
      #1;
      chk("field outputs", {22'h0, mir[1][2:0], mir[2][3:2], mir[2][1:0], mir[3][0],
          mir[0][7], mir[4][7]}, {22'h0, filt, clsd, osc, bw, s1, s2});
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, IDX[i], 32'h0, rd, er);
         chk("read data", {24'h0, mir[i]}, rd);
         chk("read error", 32'h0, {31'h0, er});
      end
      $display("test %s done", tname);
   endtask
   task automatic nvm(input logic [7:0] idx, input logic [7:0] d);
      @(posedge pclk);
      nvm_load <= 1'b1; nvm_index <= idx; nvm_data <= d;
      @(posedge pclk);
      nvm_load <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog: the whole run needs about 23000 cycles
   initial begin
      #1000000;
      fails++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin : main
      logic [31:0] rd;
      logic        er;
      int          n, len;
      fails = 0; n_compared = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; nvm_load = 1'b0;
      nvm_index = 8'h00; nvm_data = 8'h00;
      mir = '{8'h00, 8'h03, 8'h01, 8'h00, 8'h00};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      check_all("reset values");
      // all ones: reserved bits must read back zero
      for (int i = 0; i < 5; i++) wr(i, 8'hff);
      check_all("reserved bits");
      wr(1, 8'hfb);
      wr(0, 8'h7f);
      wr(4, 8'h00);
      check_all("filter and stretch");
      // unmapped index is refused without side effects
      apb(1'b1, 8'h50, 32'hff, rd, er);
      chk("unmapped error", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      apb(1'b0, IDX_CAL_CTRL, 32'h0, rd, er);
      chk("control reads zero", 32'h0, rd);
      check_all("unmapped access");
      // nvm load keeps reserved bits out and ignores unknown indices
      nvm(IDX_L1_FILTER, 8'hf7);
      nvm(IDX_L1_WAITS, 8'hf6);
      nvm(IDX_L1_BW, 8'hfe);
      nvm(8'h50, 8'hff);
      mir[1] = 8'h07; mir[2] = 8'h06; mir[3] = 8'h00;
      check_all("nvm load");
      // every wait code through the sequencer
      for (int k = 0; k < 4; k++) begin
         wr(2, 8'((k << 2) | k));
         apb(1'b1, IDX_CAL_CTRL, 32'h1, rd, er);
         n = 0;
         while (cal_busy !== 1'b1 && n < 8) begin
            @(posedge pclk);
            n++;
         end
         chk("busy rise", 32'h1, {31'h0, cal_busy});
         len = 0;
         while (cal_busy === 1'b1 && len < 25000) begin
            @(posedge pclk);
            len++;
         end
         chk("wait length ok", 32'h1, {31'h0, len >= OSC_N[k] + CLSD_N[k] &&
             len <= OSC_N[k] + CLSD_N[k] + 4});
         #1;
         chk("done flag", 32'h1, {31'h0, cal_done});
         apb(1'b0, IDX_CAL_STAT, 32'h0, rd, er);
         chk("status", 32'h2, rd);
         $display("test wait code %0d done, busy %0d cycles", k, len);
      end
      // leave the waits at the clock generator setting
      wr(2, 8'h05);
      check_all("wait fields");
      report_and_stop();
   end
endmodule
`default_nettype wire
